// ### rtl/saes_abort.sv
/*
  Abort code selector: turns the checks on one service request into a
  32-bit abort code, zero when the request is good.
  Assumes the check flags are stable in the cycle the request is valid.
*/
`timescale 1ns/1ps
module saes_abort
  import saes_pkg::*;
(
  input  wire logic        toggle_bad,
  input  wire logic        timeout,
  input  wire logic        cmd_bad,
  input  wire saes_acc_t   access,
  input  wire logic        obj_absent,
  input  wire logic        obj_wr_only,
  input  wire logic        obj_rd_only,
  input  wire logic        sub_absent,
  input  wire logic        len_long,
  input  wire logic        len_short,
  input  wire logic        len_other,
  input  wire logic        val_range,
  input  wire logic        val_big,
  input  wire logic        val_small,
  input  wire logic        max_lt_min,
  input  wire logic        map_not_ok,
  input  wire logic        map_over,
  input  wire logic        state_block,
  input  wire logic        local_block,
  input  wire logic        other_err,
  output logic [31:0]      code
);

  // Protocol faults outrank object faults: a broken frame tells
  // nothing reliable about the object it names.
  always_comb begin
    code = AB_NONE;
    if (toggle_bad)                         code = AB_TOGGLE;
    else if (timeout)                       code = AB_TIMEOUT;
    else if (cmd_bad)                       code = AB_CMD;
    else if (obj_absent)                    code = AB_NO_OBJ;
    else if (sub_absent)                    code = AB_NO_SUB;
    else if (access == SAES_ACC_READ && obj_wr_only)
      code = AB_WR_ONLY;
    else if (access != SAES_ACC_READ && obj_rd_only)
      code = AB_RD_ONLY;
    else if (len_long)                      code = AB_LEN_HI;
    else if (len_short)                     code = AB_LEN_LO;
    else if (len_other)                     code = AB_LEN;
    else if (access == SAES_ACC_MAP && map_not_ok)
      code = AB_NOT_MAP;
    else if (access == SAES_ACC_MAP && map_over)
      code = AB_MAP_LIM;
    else if (access != SAES_ACC_READ && max_lt_min)
      code = AB_MAX_MIN;
    else if (access != SAES_ACC_READ && val_big)
      code = AB_TOO_BIG;
    else if (access != SAES_ACC_READ && val_small)
      code = AB_TOO_SMALL;
    else if (access != SAES_ACC_READ && val_range)
      code = AB_RANGE;
    else if (access != SAES_ACC_READ && local_block)
      code = AB_LOCAL;
    else if (access != SAES_ACC_READ && state_block)
      code = AB_STATE;
    else if (other_err)                     code = AB_GENERAL;
  end

endmodule

// ### rtl/saes_map_check.sv
/*
  Mapping checker for one sync manager direction: entry count, entry
  lengths and the total byte count of the assignment.
  Assumes entry lengths arrive as bit counts packed eight bits apiece.
*/
`timescale 1ns/1ps
module saes_map_check
  import saes_pkg::*;
#(
  parameter int unsigned ENTRIES = MAX_ENTRIES,
  parameter int unsigned LIMIT   = MAX_SM_BYTES
)(
  input  wire logic [4:0]           count,
  input  wire logic [ENTRIES*8-1:0] lens,
  output logic                      over,
  output logic                      bad_len
);

  logic [10:0] bits;

  always_comb begin
    bits    = '0;
    bad_len = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (5'(i) < count) begin
        bits = bits + 11'(lens[i*8 +: 8]);
        if (lens[i*8 +: 8] != LEN_B8 && lens[i*8 +: 8] != LEN_B16 &&
            lens[i*8 +: 8] != LEN_B32) begin
          bad_len = 1'b1;
        end
      end
    end
    // Counting in bits keeps the sum exact; the cap is in bytes.
    over = (count > 5'(ENTRIES)) ||
           (bits > 11'(LIMIT * 8));
  end

endmodule

// ### rtl/saes_pkg.sv
/*
  Package for the service-abort, emergency and sync block: abort codes,
  emergency message fields, sync modes and mapping limits.
  Assumes one 100 MHz clock and no software-visible registers.
*/
// What this block does
// - Answer service requests anytime, one channel.
// - Abort toggle, timeout, unknown command specifier.
// - Abort write-only read, read-only write, absent.
// - Abort missing sub-index with its code.
// - Abort out-of-range, too large, too small values.
// - Abort unmappable object or mapping over limit.
// - Abort length mismatch, too long, too short.
// - Abort state, local control, general errors.
// - Free run: asynchronous, cycle at least 1 ms.
// - SM2 mode: event per output data reception.
// - DC mode: run on SYNC0, listed cycles only.
// - Queue one emergency per error occurrence.
// - Emergency message is exactly eight bytes.
// - Alarm emergency code is always FF00h.
// - Alarm message: error register, alarm id, zeros.
// - Refuse SafeOp on bad cycle or mapping.
// - Mapping max 16 entries, 8/16/32-bit lengths.
// - Sync manager assignment capped at 64 bytes.
package saes_pkg;

  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MIN_CYCLE_US  = 1000;
  localparam int unsigned US_CYCLES     = CLK_HZ / 1_000_000;
  localparam int unsigned MIN_CYCLE_CLK = MIN_CYCLE_US * US_CYCLES;
  localparam int unsigned MAX_ENTRIES   = 16;
  localparam int unsigned MAX_SM_BYTES  = 64;
  localparam int unsigned DC_MAX_MS     = 8;
  localparam int unsigned DC_Q_US       = 250;
  localparam int unsigned DC_H_US       = 500;

  localparam logic [7:0] LEN_B8  = 8'h08;
  localparam logic [7:0] LEN_B16 = 8'h10;
  localparam logic [7:0] LEN_B32 = 8'h20;

  localparam logic [31:0] AB_NONE      = 32'h0000_0000;
  localparam logic [31:0] AB_TOGGLE    = 32'h0503_0000;
  localparam logic [31:0] AB_TIMEOUT   = 32'h0504_0000;
  localparam logic [31:0] AB_CMD       = 32'h0504_0001;
  localparam logic [31:0] AB_WR_ONLY   = 32'h0601_0001;
  localparam logic [31:0] AB_RD_ONLY   = 32'h0601_0002;
  localparam logic [31:0] AB_NO_OBJ    = 32'h0602_0000;
  localparam logic [31:0] AB_NOT_MAP   = 32'h0604_0041;
  localparam logic [31:0] AB_MAP_LIM   = 32'h0604_0042;
  localparam logic [31:0] AB_LEN       = 32'h0607_0010;
  localparam logic [31:0] AB_LEN_HI    = 32'h0607_0012;
  localparam logic [31:0] AB_LEN_LO    = 32'h0607_0013;
  localparam logic [31:0] AB_NO_SUB    = 32'h0609_0011;
  localparam logic [31:0] AB_RANGE     = 32'h0609_0030;
  localparam logic [31:0] AB_TOO_BIG   = 32'h0609_0031;
  localparam logic [31:0] AB_TOO_SMALL = 32'h0609_0032;
  localparam logic [31:0] AB_MAX_MIN   = 32'h0609_0036;
  localparam logic [31:0] AB_GENERAL   = 32'h0800_0000;
  localparam logic [31:0] AB_LOCAL     = 32'h0800_0021;
  localparam logic [31:0] AB_STATE     = 32'h0800_0022;

  localparam logic [15:0] EMCY_ALARM   = 16'hFF00;
  localparam logic [15:0] EMCY_ESM     = 16'hA000;
  localparam logic [7:0]  EMCY_CHANNEL = 8'h02;
  localparam logic [7:0]  EMCY_DIAG    = 8'h0A;
  localparam int unsigned EMCY_BYTES   = 8;

  typedef enum logic [1:0] {
    SAES_FREE_RUN,
    SAES_SM2,
    SAES_DC
  } saes_mode_t;

  typedef enum logic [1:0] {
    SAES_ACC_NONE,
    SAES_ACC_READ,
    SAES_ACC_WRITE,
    SAES_ACC_MAP
  } saes_acc_t;

endpackage

// ### rtl/saes_top.sv
/*
  Communication-side logic of the drive: aborts for failed service
  requests, application timing in three sync modes, and 8-byte emergency
  messages toward the mailbox.
  Assumes the mailbox parser supplies decoded request checks on this
  clock, while SYNC0 and the SM2 event arrive from outside the domain.
*/
`timescale 1ns/1ps
module saes_top
  import saes_pkg::*;
#(
  parameter int unsigned ENTRIES = MAX_ENTRIES,
  parameter int unsigned SM_MAX  = MAX_SM_BYTES
)(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 req_valid,
  input  wire saes_acc_t            req_access,
  input  wire logic                 req_toggle_bad,
  input  wire logic                 req_timeout,
  input  wire logic                 req_cmd_bad,
  input  wire logic                 req_obj_absent,
  input  wire logic                 req_obj_wr_only,
  input  wire logic                 req_obj_rd_only,
  input  wire logic                 req_sub_absent,
  input  wire logic                 req_len_long,
  input  wire logic                 req_len_short,
  input  wire logic                 req_len_other,
  input  wire logic                 req_val_range,
  input  wire logic                 req_val_big,
  input  wire logic                 req_val_small,
  input  wire logic                 req_max_lt_min,
  input  wire logic                 req_map_not_ok,
  input  wire logic                 req_state_block,
  input  wire logic                 req_local_block,
  input  wire logic                 req_other_err,
  input  wire logic [4:0]           rx_map_count,
  input  wire logic [ENTRIES*8-1:0] rx_map_lens,
  input  wire logic [4:0]           tx_map_count,
  input  wire logic [ENTRIES*8-1:0] tx_map_lens,
  input  wire logic                 map_has_unmappable,
  input  wire logic                 map_dir_swapped,
  input  wire saes_mode_t           sync_mode,
  input  wire logic [12:0]          dc_cycle_us,
  input  wire logic                 sm2_event_pin,
  input  wire logic                 sync0_pin,
  input  wire logic                 safeop_req,
  input  wire logic                 alarm_set,
  input  wire logic [7:0]           alarm_id,
  input  wire logic [7:0]           error_reg,
  input  wire logic                 emcy_ready,
  output logic                      rsp_valid,
  output logic                      rsp_abort,
  output logic [31:0]               rsp_code,
  output logic                      app_start,
  output logic                      safeop_ok,
  output logic                      safeop_fail,
  output logic                      emcy_valid,
  output logic [63:0]               emcy_data
);

  typedef struct packed {
    logic        sm2_s1;
    logic        sm2_s2;
    logic        sm2_prev;
    logic        sy0_s1;
    logic        sy0_s2;
    logic        sy0_prev;
    logic [16:0] free_cnt;
    logic        rsp_valid;
    logic        rsp_abort;
    logic [31:0] rsp_code;
    logic        app_start;
    logic        safeop_ok;
    logic        safeop_fail;
    logic        alarm_prev;
    logic        alarm_pend;
    logic [7:0]  alarm_id;
    logic        esm_pend;
    logic        emcy_valid;
    logic [63:0] emcy_data;
  } saes_state_t;

  saes_state_t st_r;
  saes_state_t st_nxt;

  logic [31:0] abort_code;
  logic        rx_over;
  logic        rx_bad;
  logic        tx_over;
  logic        tx_bad;
  logic        map_over;
  logic        dc_ok;
  logic        sm2_rise;
  logic        sy0_rise;

  saes_map_check #(
    .ENTRIES (ENTRIES),
    .LIMIT   (SM_MAX)
  ) u_rx_map (
    .count   (rx_map_count),
    .lens    (rx_map_lens),
    .over    (rx_over),
    .bad_len (rx_bad)
  );

  saes_map_check #(
    .ENTRIES (ENTRIES),
    .LIMIT   (SM_MAX)
  ) u_tx_map (
    .count   (tx_map_count),
    .lens    (tx_map_lens),
    .over    (tx_over),
    .bad_len (tx_bad)
  );

  assign map_over = rx_over | tx_over | rx_bad | tx_bad;

  saes_abort u_abort (
    .toggle_bad  (req_toggle_bad),
    .timeout     (req_timeout),
    .cmd_bad     (req_cmd_bad),
    .access      (req_access),
    .obj_absent  (req_obj_absent),
    .obj_wr_only (req_obj_wr_only),
    .obj_rd_only (req_obj_rd_only),
    .sub_absent  (req_sub_absent),
    .len_long    (req_len_long),
    .len_short   (req_len_short),
    .len_other   (req_len_other),
    .val_range   (req_val_range),
    .val_big     (req_val_big),
    .val_small   (req_val_small),
    .max_lt_min  (req_max_lt_min),
    .map_not_ok  (req_map_not_ok),
    .map_over    (map_over),
    .state_block (req_state_block),
    .local_block (req_local_block),
    .other_err   (req_other_err),
    .code        (abort_code)
  );

  // Supported DC cycles: 250 us, 500 us, or 1..8 whole milliseconds.
  // The port is 13 bits so that 8000 us fits without wrapping onto a
  // short cycle that would then be wrongly accepted.
  always_comb begin
    dc_ok = (dc_cycle_us == 13'(DC_Q_US)) ||
            (dc_cycle_us == 13'(DC_H_US));
    for (int m = 1; m <= DC_MAX_MS; m++) begin
      if (dc_cycle_us == 13'(m * MIN_CYCLE_US)) begin
        dc_ok = 1'b1;
      end
    end
  end

  assign sm2_rise = st_r.sm2_s2 & ~st_r.sm2_prev;
  assign sy0_rise = st_r.sy0_s2 & ~st_r.sy0_prev;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.sm2_s1   = sm2_event_pin;
    st_nxt.sm2_s2   = st_r.sm2_s1;
    st_nxt.sm2_prev = st_r.sm2_s2;
    st_nxt.sy0_s1   = sync0_pin;
    st_nxt.sy0_s2   = st_r.sy0_s1;
    st_nxt.sy0_prev = st_r.sy0_s2;

    // Service answers are never held off by the sync logic, so a
    // request is answered one cycle later in every mode.
    st_nxt.rsp_valid = req_valid;
    if (req_valid) begin
      st_nxt.rsp_code  = abort_code;
      st_nxt.rsp_abort = (abort_code != AB_NONE);
    end

    st_nxt.app_start = 1'b0;
    case (sync_mode)
      SAES_FREE_RUN: begin
        // Own timebase, blind to bus traffic.
        if (st_r.free_cnt == 17'(MIN_CYCLE_CLK - 1)) begin
          st_nxt.free_cnt  = '0;
          st_nxt.app_start = 1'b1;
        end else begin
          st_nxt.free_cnt = st_r.free_cnt + 17'd1;
        end
      end
      SAES_SM2: begin
        st_nxt.free_cnt  = '0;
        st_nxt.app_start = sm2_rise;
      end
      SAES_DC: begin
        st_nxt.free_cnt  = '0;
        st_nxt.app_start = sy0_rise;
      end
      default: begin
        st_nxt.free_cnt = '0;
      end
    endcase

    st_nxt.safeop_ok   = 1'b0;
    st_nxt.safeop_fail = 1'b0;
    if (safeop_req) begin
      if ((sync_mode == SAES_DC && !dc_ok) || map_has_unmappable ||
          map_dir_swapped) begin
        st_nxt.safeop_fail = 1'b1;
        st_nxt.esm_pend    = 1'b1;
      end else begin
        st_nxt.safeop_ok = 1'b1;
      end
    end

    // Only a fresh alarm edge queues a message; a held alarm does not
    // resend, which is the one-per-occurrence behaviour.
    st_nxt.alarm_prev = alarm_set;
    if (alarm_set && !st_r.alarm_prev) begin
      st_nxt.alarm_pend = 1'b1;
      st_nxt.alarm_id   = alarm_id;
    end

    if (st_r.emcy_valid && emcy_ready) begin
      st_nxt.emcy_valid = 1'b0;
    end else if (!st_r.emcy_valid) begin
      // Byte 0 sits in bits 7:0, error code little-endian.
      if (st_r.alarm_pend) begin
        st_nxt.emcy_valid = 1'b1;
        st_nxt.emcy_data  = {24'h0, st_r.alarm_id, 8'h00, error_reg,
                             EMCY_ALARM};
        st_nxt.alarm_pend = alarm_set && !st_r.alarm_prev;
      end else if (st_r.esm_pend) begin
        st_nxt.emcy_valid = 1'b1;
        st_nxt.emcy_data  = {32'h0, EMCY_DIAG, EMCY_CHANNEL,
                             EMCY_ESM};
        st_nxt.esm_pend   = safeop_req && st_nxt.safeop_fail;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid   = st_r.rsp_valid;
  assign rsp_abort   = st_r.rsp_abort;
  assign rsp_code    = st_r.rsp_code;
  assign app_start   = st_r.app_start;
  assign safeop_ok   = st_r.safeop_ok;
  assign safeop_fail = st_r.safeop_fail;
  assign emcy_valid  = st_r.emcy_valid;
  assign emcy_data   = st_r.emcy_data;

endmodule

// ### test/saes_master_model.sv
/*
  Behavioural fieldbus master: takes emergency messages from the
  mailbox after a chosen delay and sends sync pulses on request.
  Assumes the same clock and reset as the block.
*/
`timescale 1ns/1ps
module saes_master_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        emcy_valid,
  input  wire logic [63:0] emcy_data,
  input  wire logic [3:0]  lag,
  output logic             emcy_ready,
  output logic             sm2_event_pin,
  output logic             sync0_pin
);
  logic [3:0]  wait_n;
  logic [63:0] got;
  int          n_got = 0;

  initial begin
    sm2_event_pin = 1'b0;
    sync0_pin = 1'b0;
  end

  // A slow mailbox keeps ready low for a while, so holding is exercised.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      emcy_ready <= 1'b0;
      wait_n <= 4'h0;
    end else if (emcy_valid && emcy_ready) begin
      got <= emcy_data;
      n_got <= n_got + 1;
      emcy_ready <= 1'b0;
      wait_n <= 4'h0;
    end else if (emcy_valid && wait_n >= lag) begin
      emcy_ready <= 1'b1;
    end else if (emcy_valid) begin
      wait_n <= wait_n + 4'h1;
    end
  end

  // Pulses stay high and low for four cycles, above the sync minimum.
  task pulse(input bit dc);
    @(posedge clk);
    if (dc) sync0_pin <= 1'b1;
    else sm2_event_pin <= 1'b1;
    repeat (4) @(posedge clk);
    sync0_pin <= 1'b0;
    sm2_event_pin <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### test/saes_top_assertions.sv
/*
  Checker for the service-abort, emergency and sync block.
  Assumes it is bound to saes_top and sees one clock domain only.
*/
`timescale 1ns/1ps
module saes_top_assertions
  import saes_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        req_valid,
  input wire logic        req_toggle_bad,
  input wire saes_mode_t  sync_mode,
  input wire logic        sync0_pin,
  input wire logic        safeop_req,
  input wire logic        emcy_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_abort,
  input wire logic [31:0] rsp_code,
  input wire logic        app_start,
  input wire logic        safeop_ok,
  input wire logic        safeop_fail,
  input wire logic        emcy_valid,
  input wire logic [63:0] emcy_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_rsp_next: assert property (req_valid |=> rsp_valid)
    else $error("request without answer");
  a_rsp_cause: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without request");
  a_abort_flag: assert property
    (rsp_valid |-> rsp_abort == (rsp_code != 32'h0))
    else $error("abort flag disagrees with code");
  a_toggle_first: assert property
    (req_valid && req_toggle_bad |=> rsp_code == AB_TOGGLE)
    else $error("toggle fault not reported");
  a_dc_start: assert property
    (sync_mode == SAES_DC && $rose(sync0_pin) |-> ##3 app_start)
    else $error("no start after sync pulse");
  a_start_pulse: assert property (app_start |=> !app_start)
    else $error("start longer than one cycle");
  a_safeop_one: assert property
    (safeop_req |=> safeop_ok != safeop_fail)
    else $error("transition answer missing");
  a_emcy_hold: assert property
    (emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_data))
    else $error("message changed before acceptance");
  a_emcy_drop: assert property
    (emcy_valid && emcy_ready |=> !emcy_valid)
    else $error("message sent again");
  a_alarm_form: assert property
    (emcy_valid && emcy_data[15:0] == EMCY_ALARM
     |-> emcy_data[31:24] == 8'h00 && emcy_data[63:40] == 24'h0)
    else $error("alarm message padding wrong");
  a_esm_form: assert property
    (emcy_valid && emcy_data[15:0] == EMCY_ESM
     |-> emcy_data[63:16] == {32'h0, EMCY_DIAG, EMCY_CHANNEL})
    else $error("transition message wrong");

  c_fail: cover property (safeop_req ##1 safeop_fail);
  c_take: cover property (emcy_valid && emcy_ready);
  c_abort: cover property (rsp_valid && rsp_abort);
endmodule

bind saes_top saes_top_assertions u_chk (
  .clk(clk), .resetn(resetn), .req_valid(req_valid),
  .req_toggle_bad(req_toggle_bad), .sync_mode(sync_mode),
  .sync0_pin(sync0_pin), .safeop_req(safeop_req),
  .emcy_ready(emcy_ready), .rsp_valid(rsp_valid), .rsp_abort(rsp_abort),
  .rsp_code(rsp_code), .app_start(app_start), .safeop_ok(safeop_ok),
  .safeop_fail(safeop_fail), .emcy_valid(emcy_valid),
  .emcy_data(emcy_data)
);

// ### test/saes_top_tb.sv
/*
  Self-checking bench for saes_top with a behavioural master model.
  Assumes a 100 MHz clock and the package constants of the block.
*/
`timescale 1ns/1ps
module saes_top_tb
  import saes_pkg::*;
;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  logic         req_valid = 1'b0;
  saes_acc_t    acc = SAES_ACC_NONE;
  logic [17:0]  fl = 18'h0;
  logic [4:0]   rxc = 5'h01;
  logic [4:0]   txc = 5'h01;
  logic [127:0] rxl = {16{8'h08}};
  logic [127:0] txl = {16{8'h08}};
  logic         unm = 1'b0;
  logic         swp = 1'b0;
  logic         sreq = 1'b0;
  logic         alarm_set = 1'b0;
  saes_mode_t   mode = SAES_SM2;
  logic [12:0]  dcus = 13'h03E8;
  logic [7:0]   aid = 8'h00;
  logic [7:0]   ereg = 8'h00;
  logic [3:0]   mlag = 4'h0;
  wire          sm2, sy0, rdy, rsp_valid, rsp_abort, app_start;
  wire          s_ok, s_fail, emcy_valid;
  wire [31:0]   rsp_code;
  wire [63:0]   emcy_data;
  int           n_mismatch = 0;
  int           n_compared = 0;
  int           n_start = 0;
  logic [31:0]  ex [18] = '{AB_TOGGLE, AB_TIMEOUT, AB_CMD, AB_NO_OBJ,
    AB_WR_ONLY, AB_RD_ONLY, AB_NO_SUB, AB_LEN_HI, AB_LEN_LO, AB_LEN,
    AB_RANGE, AB_TOO_BIG, AB_TOO_SMALL, AB_MAX_MIN, AB_NOT_MAP,
    AB_STATE, AB_LOCAL, AB_GENERAL};

  always #5 clk = ~clk;

  saes_top dut (
    .clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req_access(acc), .req_toggle_bad(fl[0]), .req_timeout(fl[1]),
    .req_cmd_bad(fl[2]), .req_obj_absent(fl[3]),
    .req_obj_wr_only(fl[4]), .req_obj_rd_only(fl[5]),
    .req_sub_absent(fl[6]), .req_len_long(fl[7]),
    .req_len_short(fl[8]), .req_len_other(fl[9]),
    .req_val_range(fl[10]), .req_val_big(fl[11]),
    .req_val_small(fl[12]), .req_max_lt_min(fl[13]),
    .req_map_not_ok(fl[14]), .req_state_block(fl[15]),
    .req_local_block(fl[16]), .req_other_err(fl[17]),
    .rx_map_count(rxc), .rx_map_lens(rxl), .tx_map_count(txc),
    .tx_map_lens(txl), .map_has_unmappable(unm),
    .map_dir_swapped(swp), .sync_mode(mode), .dc_cycle_us(dcus),
    .sm2_event_pin(sm2), .sync0_pin(sy0), .safeop_req(sreq),
    .alarm_set(alarm_set), .alarm_id(aid), .error_reg(ereg),
    .emcy_ready(rdy), .rsp_valid(rsp_valid), .rsp_abort(rsp_abort),
    .rsp_code(rsp_code), .app_start(app_start), .safeop_ok(s_ok),
    .safeop_fail(s_fail), .emcy_valid(emcy_valid),
    .emcy_data(emcy_data)
  );

  saes_master_model mstr (
    .clk(clk), .resetn(resetn), .emcy_valid(emcy_valid),
    .emcy_data(emcy_data), .lag(mlag), .emcy_ready(rdy),
    .sm2_event_pin(sm2), .sync0_pin(sy0)
  );

  always @(posedge clk) begin
    if (app_start === 1'b1) n_start <= n_start + 1;
  end

  task close_out;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [63:0] seen, input logic [63:0] exp,
           input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s: %h not %h", $time, what, seen, exp);
    end
  endtask

  // Every fault flag back to back, one request per cycle; the mapping limit is left to t_map.
  task t_abort;
    for (int i = 0; i <= 18; i++) begin
      @(posedge clk);
      req_valid <= (i < 18);
      fl <= (i < 18) ? 18'h00001 << i : 18'h0;
      acc <= (i == 4) ? SAES_ACC_READ :
             (i == 14) ? SAES_ACC_MAP : SAES_ACC_WRITE;
      #1;
      if (i > 0) begin
        chk(rsp_valid, 1'b1, "answer");
        chk(rsp_code, ex[i-1], "code");
      end
    end
  endtask

  task req(input saes_acc_t a, input logic [17:0] f, input logic [31:0] e);
    @(posedge clk);
    req_valid <= 1'b1;
    acc <= a;
    fl <= f;
    @(posedge clk);
    req_valid <= 1'b0;
    fl <= 18'h0;
    #1;
    chk(rsp_code, e, "code");
    chk(rsp_abort, |e, "abort flag");
  endtask

  task t_map;
    @(posedge clk);
    rxc <= 5'h10;
    txc <= 5'h10;
    rxl <= {16{8'h20}};
    txl <= {16{8'h20}};
    req(SAES_ACC_MAP, 18'h0, AB_NONE);
    rxc <= 5'h11;
    req(SAES_ACC_MAP, 18'h0, AB_MAP_LIM);
    rxc <= 5'h01;
    txc <= 5'h01;
    txl[7:0] <= 8'h18;
    req(SAES_ACC_MAP, 18'h0, AB_MAP_LIM);
    txl[7:0] <= 8'h10;
    req(SAES_ACC_MAP, 18'h0, AB_NONE);
    req(SAES_ACC_WRITE, 18'h10003, AB_TOGGLE);
    req(SAES_ACC_READ, 18'h00020, AB_NONE);
  endtask

  task t_sync(input saes_mode_t m, input bit dc, input int e);
    int b;
    @(posedge clk);
    mode <= m;
    repeat (4) @(posedge clk);
    b = n_start;
    mstr.pulse(dc);
    chk(64'(n_start - b), 64'(e), "starts");
  endtask

  task t_safeop(input logic [12:0] us, input logic u, input logic s,
                input logic ok);
    int b;
    @(posedge clk);
    mode <= SAES_DC;
    dcus <= us;
    unm <= u;
    swp <= s;
    sreq <= 1'b1;
    b = mstr.n_got;
    @(posedge clk);
    sreq <= 1'b0;
    #1;
    chk(s_ok, ok, "ok");
    chk(s_fail, !ok, "fail");
    repeat (30) @(posedge clk);
    chk(64'(mstr.n_got - b), 64'(!ok), "messages");
    if (!ok)
      chk(mstr.got, {32'h0, EMCY_DIAG, EMCY_CHANNEL, EMCY_ESM}, "esm");
  endtask

  // The alarm stays high throughout, so a repeat would show up here.
  task t_alarm(input logic [7:0] id, input logic [7:0] er,
               input logic [3:0] lag);
    int b;
    @(posedge clk);
    mlag <= lag;
    aid <= id;
    ereg <= er;
    alarm_set <= 1'b1;
    b = mstr.n_got;
    req(SAES_ACC_WRITE, 18'h08000, AB_STATE);
    repeat (40) @(posedge clk);
    chk(64'(mstr.n_got - b), 64'h1, "one message");
    chk(mstr.got, {24'h0, id, 8'h00, er, EMCY_ALARM}, "alarm");
    @(posedge clk);
    alarm_set <= 1'b0;
  endtask

  task t_free;
    int b;
    int cnt;
    @(posedge clk);
    mode <= SAES_FREE_RUN;
    b = n_start;
    cnt = 0;
    while (n_start == b && cnt < 100100) begin
      @(posedge clk);
      cnt++;
    end
    chk(cnt >= MIN_CYCLE_CLK - 2 && cnt <= MIN_CYCLE_CLK + 4, 1'b1,
        "free run period");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    t_abort;
    t_map;
    t_sync(SAES_DC, 1'b1, 1);
    t_sync(SAES_DC, 1'b0, 0);
    t_sync(SAES_SM2, 1'b0, 1);
    t_sync(SAES_SM2, 1'b1, 0);
    // 904 us is 5000 us wrapped to 12 bits and must still be refused.
    t_safeop(13'h00FA, 1'b0, 1'b0, 1'b1);
    t_safeop(13'h01F4, 1'b0, 1'b0, 1'b1);
    for (int k = 1; k <= 8; k++)
      t_safeop(13'(k * 1000), 1'b0, 1'b0, 1'b1);
    t_safeop(13'h02EE, 1'b0, 1'b0, 1'b0);
    t_safeop(13'h05DC, 1'b0, 1'b0, 1'b0);
    t_safeop(13'h0388, 1'b0, 1'b0, 1'b0);
    t_safeop(13'h03E8, 1'b1, 1'b0, 1'b0);
    t_safeop(13'h03E8, 1'b0, 1'b1, 1'b0);
    t_alarm(8'h5A, 8'h81, 4'h0);
    t_alarm(8'hC3, 8'h01, 4'h9);
    t_free;
    close_out;
  end

  initial begin
    repeat (103000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
endmodule
